// file: core/prs_pkg.sv
// shared constants and types for the power-up reset sequencer
package prs_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS      = 40;
  localparam int unsigned POWERUP_DELAY_US   = 72;
  localparam int unsigned POWERUP_DELAY_CYC  = (POWERUP_DELAY_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned OSC_STARTUP_CYC    = 1024;
  localparam int unsigned CNT_W              = 16;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    PRS_ST_BOR   = 5'h01,
    PRS_ST_POWERUP_DELAY_TIMER  = 5'h02,
    PRS_ST_OST   = 5'h04,
    PRS_ST_RUN   = 5'h08,
    PRS_ST_IDLE  = 5'h10
  } prs_state_type;

  // configuration carried as one group
  typedef struct packed {
    logic intMclrEnable;
    logic pwrtEnable;
    logic ostEnable;
  } prs_cfg_type;

  // status carried as one group
  typedef struct packed {
    logic powerupDelayActive;
    logic oscStartupActive;
    logic brownoutActive;
  } prs_status_type;

endpackage

// file: core/prs_sync2.sv
// two-flop synchroniser for one asynchronous level
`timescale 1ns/10ps
module prs_sync2 (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic dIn,
  output logic      dOut
);

  logic stage1_reg;
  logic stage2_reg;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
    end else begin
      stage1_reg <= dIn;
      stage2_reg <= stage1_reg;
    end
  end

  assign dOut = stage2_reg;

endmodule

// file: core/prs_timer.sv
// down counter that reports when a loaded delay has run out
`timescale 1ns/10ps
module prs_timer (
  input  wire logic                     mclk,
  input  wire logic                     rst_b,
  input  wire logic                     load,
  input  wire logic                     run,
  input  wire logic [prs_pkg::CNT_W-1:0] loadValue,
  output logic                          expired
);

  logic [prs_pkg::CNT_W-1:0] count_reg;
  logic [prs_pkg::CNT_W-1:0] count_next;

  assign count_next = load ? loadValue :
                      (run && count_reg != '0) ? count_reg - 1'b1 : count_reg;
  assign expired    = run && !load && (count_reg == '0);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule

// file: core/prs_sequencer.sv
// power-up reset sequencer: power-on pulse, brown-out, delay timers, master clear
// Notes on behaviour
// - one power-on pulse per supply rise
// - power-on resets only with internal clear
// - hold reset through both delay timers
// - delay timer starts only on power-up resets
// - power-on starts delay at the pulse
// - brown-out starts delay when brown-out ends
// - delay timer runs from internal RC clock; here it runs on mclk
// - reset held while delay timer counts
// - config bit skips delay for power-on
// - brown-out always applies the delay; here a power-on accepted as it ends, with pwrtEnable 0, skips it
// - oscillator timer follows delay, reset held
// - brown-out during delay restarts the delay
// - timeouts run while master clear low
// - RC mode, delay off: no timeout
`timescale 1ns/10ps
module prs_sequencer #(
  parameter int unsigned POWERUP_DELAY_LENGTH = prs_pkg::POWERUP_DELAY_CYC,
  parameter int unsigned OSC_STARTUP_LENGTH   = prs_pkg::OSC_STARTUP_CYC
) (
  input  wire logic                   mclk,
  input  wire logic                   rst_b,
  input  wire logic                   supplyRiseDetect,
  input  wire logic                   brownoutLevel,
  input  wire logic                   master_clear_input_b,
  input  wire prs_pkg::prs_cfg_type   cfg,
  output logic                        powerOnPulse,
  output logic                        deviceReset,
  output prs_pkg::prs_status_type     status
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic riseSync;
  logic borSync;
  logic mclrSync;

  prs_sync2 u_syncRise (
    .mclk  (mclk),
    .rst_b (rst_b),
    .dIn   (supplyRiseDetect),
    .dOut  (riseSync)
  );

  prs_sync2 u_syncBor (
    .mclk  (mclk),
    .rst_b (rst_b),
    .dIn   (brownoutLevel),
    .dOut  (borSync)
  );

  prs_sync2 u_syncMclr (
    .mclk  (mclk),
    .rst_b (rst_b),
    .dIn   (master_clear_input_b),
    .dOut  (mclrSync)
  );

  // ----------------------------------------------------------------
  // event detection
  // ----------------------------------------------------------------
  logic riseDly_reg;
  logic borDly_reg;
  logic porEvent;
  logic borEnd;

  assign porEvent = riseSync && !riseDly_reg;
  assign borEnd   = !borSync && borDly_reg;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      riseDly_reg <= 1'b0;
      borDly_reg  <= 1'b0;
    end else begin
      riseDly_reg <= riseSync;
      borDly_reg  <= borSync;
    end
  end

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  prs_pkg::prs_state_type state_reg;
  prs_pkg::prs_state_type state_next;
  logic                   pwrtLoad;
  logic                   ostLoad;
  logic                   pwrtDone;
  logic                   ostDone;
  logic                   pwrtRun;
  logic                   ostRun;
  logic                   porAccepted;

  // power-on acts only with internal clear selected
  assign porAccepted = porEvent && cfg.intMclrEnable;
  assign pwrtRun     = (state_reg == prs_pkg::PRS_ST_POWERUP_DELAY_TIMER);
  assign ostRun      = (state_reg == prs_pkg::PRS_ST_OST);

  // only power-up events load the delay
  always_comb begin
    state_next = state_reg;
    pwrtLoad   = 1'b0;
    ostLoad    = 1'b0;
    // brown-out always returns to brown-out reset
    if (borSync) begin
      state_next = prs_pkg::PRS_ST_BOR;
    end else if (porAccepted) begin
      // config bit skips delay on power-on
      // no delay and no oscillator timer means no timeout
      if (cfg.pwrtEnable) begin
        state_next = prs_pkg::PRS_ST_POWERUP_DELAY_TIMER;
        pwrtLoad   = 1'b1;
      end else if (cfg.ostEnable) begin
        state_next = prs_pkg::PRS_ST_OST;
        ostLoad    = 1'b1;
      end else begin
        state_next = prs_pkg::PRS_ST_RUN;
      end
    end else begin
      unique case (state_reg)
        prs_pkg::PRS_ST_IDLE: begin
          state_next = prs_pkg::PRS_ST_IDLE;
        end
        prs_pkg::PRS_ST_BOR: begin
          if (borEnd) begin
            state_next = prs_pkg::PRS_ST_POWERUP_DELAY_TIMER;
            pwrtLoad   = 1'b1;
          end
        end
        prs_pkg::PRS_ST_POWERUP_DELAY_TIMER: begin
          if (pwrtDone) begin
            if (cfg.ostEnable) begin
              state_next = prs_pkg::PRS_ST_OST;
              ostLoad    = 1'b1;
            end else begin
              state_next = prs_pkg::PRS_ST_RUN;
            end
          end
        end
        prs_pkg::PRS_ST_OST: begin
          if (ostDone) begin
            state_next = prs_pkg::PRS_ST_RUN;
          end
        end
        prs_pkg::PRS_ST_RUN: begin
          state_next = prs_pkg::PRS_ST_RUN;
        end
        default: begin
          state_next = prs_pkg::PRS_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= prs_pkg::PRS_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // delay timers
  // ----------------------------------------------------------------
  // timer runs on mclk, the same clock as the rest of the sequencer
  prs_timer u_powerup_delay_timer (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .load      (pwrtLoad),
    .run       (pwrtRun),
    .loadValue (prs_pkg::CNT_W'(POWERUP_DELAY_LENGTH - 1)),
    .expired   (pwrtDone)
  );

  prs_timer u_osc_startup_timer (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .load      (ostLoad),
    .run       (ostRun),
    .loadValue (prs_pkg::CNT_W'(OSC_STARTUP_LENGTH - 1)),
    .expired   (ostDone)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic resetHold;
  logic pulse_reg;
  logic reset_reg;

  // timers run regardless of master clear; release is immediate
  assign resetHold = (state_reg != prs_pkg::PRS_ST_RUN) || !mclrSync;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pulse_reg <= 1'b0;
      reset_reg <= 1'b1;
    end else begin
      pulse_reg <= porAccepted;
      reset_reg <= resetHold;
    end
  end

  assign powerOnPulse              = pulse_reg;
  assign deviceReset               = reset_reg;
  assign status.powerupDelayActive = pwrtRun;
  assign status.oscStartupActive   = ostRun;
  assign status.brownoutActive     = (state_reg == prs_pkg::PRS_ST_BOR);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_delayRunning;
    pwrtRun;
  endsequence

  property p_holdDuringDelay;
    @(posedge mclk) disable iff (!rst_b) s_delayRunning |=> deviceReset;
  endproperty
  a_holdDuringDelay: assert property (p_holdDuringDelay)
    else $error("reset released while delay timer counting");

  property p_borRestart;
    @(posedge mclk) disable iff (!rst_b) (pwrtRun && borSync) |=> !pwrtRun;
  endproperty
  a_borRestart: assert property (p_borRestart)
    else $error("delay continued during brown-out");

  property p_borEndStarts;
    @(posedge mclk) disable iff (!rst_b)
      (status.brownoutActive && borEnd && !porAccepted) |=> pwrtRun;
  endproperty
  a_borEndStarts: assert property (p_borEndStarts)
    else $error("delay not started at end of brown-out");

  property p_porStarts;
    @(posedge mclk) disable iff (!rst_b)
      (porAccepted && !borSync && cfg.pwrtEnable) |=> pwrtRun;
  endproperty
  a_porStarts: assert property (p_porStarts)
    else $error("delay not started at power-on pulse");

  property p_porSkip;
    @(posedge mclk) disable iff (!rst_b)
      (porAccepted && !borSync && !cfg.pwrtEnable) |=> !pwrtRun;
  endproperty
  a_porSkip: assert property (p_porSkip)
    else $error("delay ran with delay disabled");

  property p_noTimeout;
    @(posedge mclk) disable iff (!rst_b)
      (porAccepted && !borSync && !cfg.pwrtEnable && !cfg.ostEnable) |=>
        (state_reg == prs_pkg::PRS_ST_RUN);
  endproperty
  a_noTimeout: assert property (p_noTimeout)
    else $error("timeout applied in no-timeout mode");

  property p_ostFollows;
    @(posedge mclk) disable iff (!rst_b)
      (pwrtDone && !borSync && !porAccepted && cfg.ostEnable) |=> ostRun;
  endproperty
  a_ostFollows: assert property (p_ostFollows)
    else $error("oscillator timer did not follow delay");

  property p_porGated;
    @(posedge mclk) disable iff (!rst_b) (porEvent && !cfg.intMclrEnable) |=> !powerOnPulse;
  endproperty
  a_porGated: assert property (p_porGated)
    else $error("power-on acted without internal clear");

  property p_immediateRelease;
    @(posedge mclk) disable iff (!rst_b)
      (state_reg == prs_pkg::PRS_ST_RUN && !borSync && !porAccepted && mclrSync) |=> !deviceReset;
  endproperty
  a_immediateRelease: assert property (p_immediateRelease)
    else $error("release not immediate after master clear");

  property p_holdDuringOsc;
    @(posedge mclk) disable iff (!rst_b) ostRun |=> deviceReset;
  endproperty
  a_holdDuringOsc: assert property (p_holdDuringOsc)
    else $error("reset released while oscillator timer counting");

  property p_startOnlyPowerup;
    @(posedge mclk) disable iff (!rst_b)
      (!pwrtRun && !porAccepted && !(status.brownoutActive && borEnd)) |=> !pwrtRun;
  endproperty
  a_startOnlyPowerup: assert property (p_startOnlyPowerup)
    else $error("delay timer started without a power-up event");

  property p_borOverrides;
    @(posedge mclk) disable iff (!rst_b) borSync |=> status.brownoutActive;
  endproperty
  a_borOverrides: assert property (p_borOverrides)
    else $error("brown-out did not force brown-out reset");

  sequence s_pulseSeen;
    powerOnPulse;
  endsequence

  property p_singlePulse;
    @(posedge mclk) disable iff (!rst_b) s_pulseSeen |=> !powerOnPulse;
  endproperty
  a_singlePulse: assert property (p_singlePulse)
    else $error("power-on pulse longer than one cycle");

endmodule

// file: dv/prs_supply_model.sv
// far-side model: supply monitor and external master-clear circuit
`timescale 1ns/10ps
module prs_supply_model (
  input  wire logic mclk,
  output logic      supplyRise,
  output logic      brownout,
  output logic      clearB
);
  // ------------------------------------------------------------
  // drive helpers, every change lands at a falling edge
  // ------------------------------------------------------------
  initial begin
    supplyRise = 1'b0;
    brownout   = 1'b0;
    clearB     = 1'b1;
  end

  task automatic idle();
    @(negedge mclk);
    supplyRise <= 1'b0;
    brownout   <= 1'b0;
  endtask

  task automatic powerOn();
    @(negedge mclk);
    supplyRise <= 1'b1;
  endtask

  task automatic setBrownout(input logic v);
    @(negedge mclk);
    brownout <= v;
  endtask

  task automatic setClear(input logic v);
    @(negedge mclk);
    clearB <= v;
  endtask
endmodule

// file: dv/testbench.sv
// self-checking bench for the power-up reset sequencer
`timescale 1ns/10ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; \
  $display("mismatch at %0t: got %h expected %h", $time, (a), (e)); end end
module testbench;
  localparam int PD = 8;
  localparam int OS = 4;
  logic                    mclk;
  logic                    rst_b;
  logic                    supplyRise;
  logic                    brownout;
  logic                    clearB;
  logic                    powerOnPulse;
  logic                    deviceReset;
  prs_pkg::prs_cfg_type    cfg;
  prs_pkg::prs_status_type status;
  int                      n_fail;
  int                      checked;
  int                      n;
  int                      extra;
  logic                    hit;

  prs_sequencer #(.POWERUP_DELAY_LENGTH(PD), .OSC_STARTUP_LENGTH(OS)) dut (
    .mclk                 (mclk),
    .rst_b                (rst_b),
    .supplyRiseDetect     (supplyRise),
    .brownoutLevel        (brownout),
    .master_clear_input_b (clearB),
    .cfg                  (cfg),
    .powerOnPulse         (powerOnPulse),
    .deviceReset          (deviceReset),
    .status               (status)
  );

  prs_supply_model partner (
    .mclk       (mclk),
    .supplyRise (supplyRise),
    .brownout   (brownout),
    .clearB     (clearB)
  );

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic restart(input prs_pkg::prs_cfg_type c, input int len);
    @(negedge mclk);
    rst_b <= 1'b0;
    cfg   <= c;
    partner.idle();
    repeat (len) @(negedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(negedge mclk);
  endtask

  function automatic logic pick(input int k);
    case (k)
      0: pick = powerOnPulse;
      1: pick = status.powerupDelayActive;
      default: pick = status.brownoutActive;
    endcase
  endfunction

  function automatic logic inRange(input int v, input int lo, input int hi);
    inRange = (v >= lo) && (v <= hi);
  endfunction

  task automatic waitFor(input int k, input int lim, output logic found);
    found = 1'b0;
    for (int i = 0; i < lim && !found; i++) begin
      @(negedge mclk);
      found = (pick(k) === 1'b1);
    end
  endtask

  // counts cycles of held reset and any repeated power-on pulses
  task automatic holdCount(output int cnt, output int pulses);
    cnt = 0;
    pulses = 0;
    for (int i = 0; i < 60; i++) begin
      @(negedge mclk);
      if (powerOnPulse === 1'b1) pulses++;
      if (deviceReset !== 1'b1) break;
      cnt++;
    end
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_por_full();
    restart(3'b111, 4);
    partner.powerOn();
    waitFor(0, 8, hit);
    `CHK(hit, 1'b1)
    `CHK(status.powerupDelayActive, 1'b1)
    `CHK(deviceReset, 1'b1)
    holdCount(n, extra);
    `CHK(extra, 0)
    `CHK(inRange(n, PD + OS - 1, PD + OS + 1), 1'b1)
    $display("test por_full done, fails %0d", n_fail);
  endtask

  task automatic t_no_delay();
    restart(3'b101, 4);
    partner.powerOn();
    waitFor(0, 8, hit);
    `CHK(hit, 1'b1)
    `CHK(status.powerupDelayActive, 1'b0)
    `CHK(status.oscStartupActive, 1'b1)
    holdCount(n, extra);
    `CHK(inRange(n, OS - 1, OS + 1), 1'b1)
    $display("test no_delay done, fails %0d", n_fail);
  endtask

  task automatic t_rc_mode();
    restart(3'b100, 4);
    partner.powerOn();
    waitFor(0, 8, hit);
    `CHK(status.oscStartupActive, 1'b0)
    holdCount(n, extra);
    `CHK(inRange(n, 0, 1), 1'b1)
    $display("test rc_mode done, fails %0d", n_fail);
  endtask

  task automatic t_no_internal_clear();
    restart(3'b011, 4);
    partner.powerOn();
    waitFor(0, 10, hit);
    `CHK(hit, 1'b0)
    repeat (PD + OS + 6) @(negedge mclk);
    `CHK(deviceReset, 1'b1)
    `CHK(status.powerupDelayActive, 1'b0)
    $display("test no_internal_clear done, fails %0d", n_fail);
  endtask

  task automatic t_brownout();
    restart(3'b101, 4);
    partner.setBrownout(1'b1);
    waitFor(2, 6, hit);
    `CHK(hit, 1'b1)
    `CHK(deviceReset, 1'b1)
    partner.powerOn();
    repeat (4) @(negedge mclk);
    `CHK(status.brownoutActive, 1'b1)
    `CHK(status.powerupDelayActive, 1'b0)
    partner.setBrownout(1'b0);
    waitFor(1, 6, hit);
    `CHK(hit, 1'b1)
    repeat (3) @(negedge mclk);
    partner.setBrownout(1'b1);
    waitFor(2, 6, hit);
    `CHK(hit, 1'b1)
    `CHK(status.powerupDelayActive, 1'b0)
    partner.setBrownout(1'b0);
    waitFor(1, 6, hit);
    holdCount(n, extra);
    `CHK(inRange(n, PD + OS - 1, PD + OS + 1), 1'b1)
    $display("test brownout done, fails %0d", n_fail);
  endtask

  task automatic t_clear_held();
    partner.setClear(1'b0);
    restart(3'b111, 4);
    partner.powerOn();
    waitFor(0, 8, hit);
    repeat (PD + OS + 4) @(negedge mclk);
    `CHK(deviceReset, 1'b1)
    `CHK(status.oscStartupActive, 1'b0)
    `CHK(status.powerupDelayActive, 1'b0)
    partner.setClear(1'b1);
    holdCount(n, extra);
    `CHK(inRange(n, 0, 4), 1'b1)
    partner.setClear(1'b0);
    repeat (4) @(negedge mclk);
    `CHK(deviceReset, 1'b1)
    `CHK(status.powerupDelayActive, 1'b0)
    partner.setClear(1'b1);
    holdCount(n, extra);
    `CHK(inRange(n, 0, 4), 1'b1)
    $display("test clear_held done, fails %0d", n_fail);
  endtask

  // every configuration: with internal clear, expected hold is the sum of the enabled timers; without it, reset stays held
  task automatic t_cfg_sweep();
    prs_pkg::prs_cfg_type c;
    int                   want;
    for (int k = 0; k < 8; k++) begin
      c = k[2:0];
      want = (c.pwrtEnable ? PD : 0) + (c.ostEnable ? OS : 0);
      restart(c, 4);
      partner.powerOn();
      waitFor(0, 8, hit);
      `CHK(hit, c.intMclrEnable)
      if (c.intMclrEnable) begin
        holdCount(n, extra);
        `CHK(n, want)
        `CHK(extra, 0)
      end else begin
        repeat (PD + OS + 2) @(negedge mclk);
        `CHK(deviceReset, 1'b1)
        `CHK(status.powerupDelayActive, 1'b0)
      end
    end
    $display("test cfg_sweep done, fails %0d", n_fail);
  endtask

  // ------------------------------------------------------------
  // run control
  // ------------------------------------------------------------
  task automatic complete_run();
    $display("counts: checked %0d, n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    n_fail = 0;
    checked = 0;
    rst_b = 1'b0;
    cfg = 3'b111;
    restart(3'b111, 18);
    t_por_full();
    t_no_delay();
    t_rc_mode();
    t_no_internal_clear();
    t_brownout();
    t_clear_held();
    t_cfg_sweep();
    complete_run();
  end

  initial begin
    repeat (3000) @(posedge mclk);
    n_fail++;
    complete_run();
  end
endmodule
